// >>> rtl/tmh_pkg.sv
// Purpose: constants for the dual 8-bit timer control block
// Assumes: 8-bit data, 16-bit byte addresses
// Notes:   unit 1 alone offers carrier mode
package tmh_pkg;

    // ------------------------------------------------------------
    // register addresses
    // ------------------------------------------------------------
    localparam logic [15:0] ADDR_PORT1_DIR  = 16'hff21;
    localparam logic [15:0] ADDR_MODE0      = 16'hff69;
    localparam logic [15:0] ADDR_MODE1      = 16'hff6c;
    localparam logic [15:0] ADDR_CARRIER    = 16'hff6d;
    localparam logic [15:0] ADDR_PERIOD0    = 16'hff18;
    localparam logic [15:0] ADDR_DUTY0      = 16'hff19;
    localparam logic [15:0] ADDR_PERIOD1    = 16'hff1a;
    localparam logic [15:0] ADDR_DUTY1      = 16'hff1b;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0]  RST_PORT1_DIR   = 8'hff;
    localparam logic [7:0]  RST_MODE        = 8'h00;
    localparam logic [7:0]  RST_CARRIER     = 8'h00;
    localparam logic [7:0]  RST_COMPARE     = 8'h00;

    // ------------------------------------------------------------
    // mode register fields
    // ------------------------------------------------------------
    localparam int          RUN_BIT         = 7;
    localparam int          CKS_MSB         = 6;
    localparam int          CKS_LSB         = 4;
    localparam int          OPM_MSB         = 3;
    localparam int          OPM_LSB         = 2;
    localparam int          LEVEL_BIT       = 1;
    localparam int          GATE_BIT        = 0;

    // ------------------------------------------------------------
    // carrier control fields
    // ------------------------------------------------------------
    localparam int          REMOTE_BIT      = 2;
    localparam int          BUFFER_BIT      = 1;
    localparam int          STATUS_BIT      = 0;

    // ------------------------------------------------------------
    // port pins of the timer outputs
    // ------------------------------------------------------------
    localparam int          PIN_TIMER0      = 5;
    localparam int          PIN_TIMER1      = 6;

    // ------------------------------------------------------------
    // operation modes and clock codes
    // ------------------------------------------------------------
    localparam logic [1:0]  OPM_INTERVAL    = 2'h0;
    localparam logic [1:0]  OPM_CARRIER     = 2'h1;
    localparam logic [1:0]  OPM_PWM         = 2'h2;
    localparam logic [2:0]  CKS_DIV1        = 3'h0;
    localparam logic [2:0]  CKS_DIV2        = 3'h1;
    localparam logic [2:0]  CKS_DIV4        = 3'h2;
    localparam logic [2:0]  CKS_DIV64       = 3'h3;
    localparam logic [2:0]  CKS_DIV1024     = 3'h4;
    localparam logic [2:0]  CKS_COMPANION   = 3'h5;
    localparam int          PRESCALE_BITS   = 12;

endpackage : tmh_pkg

// >>> rtl/tmh_timer_ctrl.sv
// Purpose: control, interval and output logic of two 8-bit timers
// Assumes: one clock, synchronous active-low reset, 8-bit register port
// Notes:   read data is registered, valid one cycle after the address
//
// Summary of operation
// - run bit low stops and zeroes the counter; high counts each selected tick
// - unit 0 clock: prescale by 1,2,4,64,1024 or companion timer output
// - mode 00 interval, 10 pwm, 01 carrier on unit 1 only
// - idle level bit sets output level while output is at default
// - output gate bit blocks or passes the generated waveform
// - interval mode with output gated on gives 50 percent square wave
// - reset clears both mode registers and carrier control
// - remote output low, high, or carrier pulse per status and remote bits
// - carrier status flag shows disabled 0 or enabled 1
// - carrier status flag is read only, set by hardware
// - direction bit 0 drives the pin, 1 releases it; reset all ones
// - interval match with period raises interrupt and clears counter
// - duty compare is ignored in interval mode
// - period match also inverts the timer output
// - stopping returns interrupt and, outside carrier mode, output to default levels
`timescale 1ns/10ps

module tmh_timer_ctrl
    import tmh_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire logic [15:0] bus_addr,
    input  wire logic       bus_wr,
    input  wire logic [7:0] bus_wdata,
    output logic      [7:0] bus_rdata,
    input  wire logic       companion_timer,
    input  wire logic       carrier_transfer,
    output logic      [1:0] timer_output_pin,
    output logic      [1:0] timer_output_oe_b,
    output logic      [1:0] match_interrupt,
    output logic      [7:0] port1_direction
);

    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    logic [7:0]               mode_reg [2];
    logic [7:0]               period_reg [2];
    logic [7:0]               duty_reg [2];
    logic [7:0]               duty_pend_reg [2];
    logic [1:0]               duty_pend_valid_reg;
    logic [7:0]               cnt_reg [2];
    logic [1:0]               flip_reg;
    logic [2:0]               carrier_reg;
    logic [PRESCALE_BITS-1:0] prescale_reg;
    logic [2:0]               comp_sync_reg;
    logic [2:0]               xfer_sync_reg;
    logic [1:0]               tick;
    logic [1:0]               wave;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic sel_tick(input logic unit, input logic [2:0] code,
                                      input logic [PRESCALE_BITS-1:0] pre, input logic comp_edge);
        logic t;
        t = 1'b0;
        if (!unit)
        begin
            unique case (code)
                CKS_DIV1:      t = 1'b1;
                CKS_DIV2:      t = pre[0];
                CKS_DIV4:      t = &pre[1:0];
                CKS_DIV64:     t = &pre[5:0];
                CKS_DIV1024:   t = &pre[9:0];
                CKS_COMPANION: t = comp_edge;
                default:       t = 1'b0;
            endcase
        end
        else
        begin
            unique case (code)
                3'h0:    t = 1'b1;
                3'h1:    t = &pre[1:0];
                3'h2:    t = &pre[3:0];
                3'h3:    t = &pre[5:0];
                3'h4:    t = &pre[11:0];
                default: t = 1'b0;
            endcase
        end
        return t;
    endfunction : sel_tick

    function automatic logic [7:0] read_mux(input logic [15:0] a);
        logic [7:0] d;
        d = 8'h00;
        unique case (a)
            ADDR_PORT1_DIR: d = port1_direction;
            ADDR_MODE0:     d = mode_reg[0];
            ADDR_MODE1:     d = mode_reg[1];
            ADDR_CARRIER:   d = {5'h00, carrier_reg};
            ADDR_PERIOD0:   d = period_reg[0];
            ADDR_DUTY0:     d = duty_reg[0];
            ADDR_PERIOD1:   d = period_reg[1];
            ADDR_DUTY1:     d = duty_reg[1];
            default:        d = 8'h00;
        endcase
        return d;
    endfunction : read_mux

    // ------------------------------------------------------------
    // prescaler and input synchronisers
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!rst_b)
            prescale_reg <= '0;
        else
            prescale_reg <= prescale_reg + 1'b1;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            comp_sync_reg <= 3'h0;
            xfer_sync_reg <= 3'h0;
        end
        else
        begin
            comp_sync_reg <= {comp_sync_reg[1:0], companion_timer};
            xfer_sync_reg <= {xfer_sync_reg[1:0], carrier_transfer};
        end
    end

    // ------------------------------------------------------------
    // shared registers
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!rst_b)
            port1_direction <= RST_PORT1_DIR;
        else if (bus_wr && bus_addr == ADDR_PORT1_DIR)
            port1_direction <= bus_wdata;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
            carrier_reg <= RST_CARRIER[2:0];
        else
        begin
            if (bus_wr && bus_addr == ADDR_CARRIER)
            begin
                carrier_reg[REMOTE_BIT] <= bus_wdata[REMOTE_BIT];
                carrier_reg[BUFFER_BIT] <= bus_wdata[BUFFER_BIT];
            end
            // status follows the buffered level on each transfer event
            if (xfer_sync_reg[1] && !xfer_sync_reg[2])
                carrier_reg[STATUS_BIT] <= carrier_reg[BUFFER_BIT];
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
            bus_rdata <= 8'h00;
        else
            bus_rdata <= read_mux(bus_addr);
    end

    // ------------------------------------------------------------
    // timer units
    // ------------------------------------------------------------
    genvar u;
    generate
        for (u = 0; u < 2; u++)
        begin : g_unit
            localparam logic [15:0] A_MODE   = u ? ADDR_MODE1 : ADDR_MODE0;
            localparam logic [15:0] A_PERIOD = u ? ADDR_PERIOD1 : ADDR_PERIOD0;
            localparam logic [15:0] A_DUTY   = u ? ADDR_DUTY1 : ADDR_DUTY0;
            localparam int          PIN      = u ? PIN_TIMER1 : PIN_TIMER0;
            logic       run;
            logic [1:0] opm;
            logic       is_pwm;
            logic       is_carrier;
            logic       hit_period;
            logic       hit_duty;

            assign run        = mode_reg[u][RUN_BIT];
            assign opm        = mode_reg[u][OPM_MSB:OPM_LSB];
            assign is_pwm     = (opm == OPM_PWM);
            assign is_carrier = (u == 1) && (opm == OPM_CARRIER);
            assign tick[u]    = sel_tick(u == 1, mode_reg[u][CKS_MSB:CKS_LSB], prescale_reg,
                                         comp_sync_reg[1] & ~comp_sync_reg[2]);
            assign hit_period = (cnt_reg[u] == period_reg[u]);
            assign hit_duty   = (cnt_reg[u] == duty_reg[u]) && (is_pwm || is_carrier);

            always_ff @(posedge clk)
            begin
                if (!rst_b)
                begin
                    mode_reg[u]   <= RST_MODE;
                    period_reg[u] <= RST_COMPARE;
                end
                else
                begin
                    if (bus_wr && bus_addr == A_MODE)
                        mode_reg[u] <= bus_wdata;
                    if (bus_wr && bus_addr == A_PERIOD)
                        period_reg[u] <= bus_wdata;
                end
            end

            // duty writes while running wait for a match of the old value
            always_ff @(posedge clk)
            begin
                if (!rst_b)
                begin
                    duty_reg[u]            <= RST_COMPARE;
                    duty_pend_reg[u]       <= RST_COMPARE;
                    duty_pend_valid_reg[u] <= 1'b0;
                end
                else if (bus_wr && bus_addr == A_DUTY)
                begin
                    duty_pend_reg[u]       <= bus_wdata;
                    duty_pend_valid_reg[u] <= run;
                    if (!run)
                        duty_reg[u] <= bus_wdata;
                end
                else if (duty_pend_valid_reg[u] && run && tick[u] && hit_duty)
                begin
                    duty_reg[u]            <= duty_pend_reg[u];
                    duty_pend_valid_reg[u] <= 1'b0;
                end
            end

            always_ff @(posedge clk)
            begin
                if (!rst_b || !run)
                begin
                    cnt_reg[u]         <= 8'h00;
                    flip_reg[u]        <= 1'b0;
                    match_interrupt[u] <= 1'b0;
                end
                else if (tick[u])
                begin
                    match_interrupt[u] <= 1'b0;
                    cnt_reg[u]         <= cnt_reg[u] + 8'h01;
                    if (is_carrier)
                    begin
                        // low phase ends on period, high phase on duty
                        if (flip_reg[u] ? hit_duty : hit_period)
                        begin
                            cnt_reg[u]         <= 8'h00;
                            flip_reg[u]        <= ~flip_reg[u];
                            match_interrupt[u] <= 1'b1;
                        end
                    end
                    else if (hit_period)
                    begin
                        cnt_reg[u]         <= 8'h00;
                        flip_reg[u]        <= ~flip_reg[u];
                        match_interrupt[u] <= 1'b1;
                    end
                    else if (hit_duty)
                        flip_reg[u] <= ~flip_reg[u];
                end
                else
                    match_interrupt[u] <= 1'b0;
            end

            assign wave[u] = mode_reg[u][LEVEL_BIT] ^ flip_reg[u];

            always_ff @(posedge clk)
            begin
                if (!rst_b)
                begin
                    timer_output_pin[u]  <= 1'b0;
                    timer_output_oe_b[u] <= 1'b1;
                end
                else
                begin
                    timer_output_oe_b[u] <= port1_direction[PIN];
                    if (!mode_reg[u][GATE_BIT])
                        timer_output_pin[u] <= mode_reg[u][LEVEL_BIT];
                    else if (is_carrier)
                        timer_output_pin[u] <= carrier_reg[STATUS_BIT] &
                                               (~carrier_reg[REMOTE_BIT] | wave[u]);
                    else
                        timer_output_pin[u] <= wave[u];
                end
            end
        end
    endgenerate

endmodule : tmh_timer_ctrl

// >>> bench/tmh_timer_ctrl_sva.sv
// Purpose: port checks of the dual timer control block
// Assumes: one clock, synchronous active-low reset
// Notes:   shadows unit 0 mode and period from bus writes
`timescale 1ns/10ps

module tmh_timer_ctrl_chk
    import tmh_pkg::*;
(
    input logic        clk,
    input logic        rst_b,
    input logic [15:0] bus_addr,
    input logic        bus_wr,
    input logic [7:0]  bus_wdata,
    input logic [7:0]  bus_rdata,
    input logic        companion_timer,
    input logic        carrier_transfer,
    input logic [1:0]  timer_output_pin,
    input logic [1:0]  timer_output_oe_b,
    input logic [1:0]  match_interrupt,
    input logic [7:0]  port1_direction
);
    logic [7:0] mode_reg;
    logic [7:0] per_reg;
    logic [9:0] gap_reg;
    logic [9:0] age_reg;
    wire        wr_cfg = bus_wr && (bus_addr == ADDR_MODE0 || bus_addr == ADDR_PERIOD0);
    // steady: div1 interval run, first match since config already past
    wire        steady = age_reg > {2'b00, per_reg} + 10'h002 && mode_reg[7] && mode_reg[6:2] == 5'h00;

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            mode_reg <= RST_MODE;
            per_reg  <= RST_COMPARE;
        end
        else if (bus_wr && bus_addr == ADDR_MODE0)
            mode_reg <= bus_wdata;
        else if (bus_wr && bus_addr == ADDR_PERIOD0)
            per_reg <= bus_wdata;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b || wr_cfg)
            age_reg <= 10'h000;
        else if (age_reg != 10'h3ff)
            age_reg <= age_reg + 10'h001;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b || match_interrupt[0])
            gap_reg <= 10'h001;
        else if (gap_reg != 10'h3ff)
            gap_reg <= gap_reg + 10'h001;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    reset_values_a: assert property ($rose(rst_b) |-> port1_direction == RST_PORT1_DIR
        && match_interrupt == 2'b00 && timer_output_oe_b == 2'b11) else $error("outputs not at reset values");
    oe_follow_a: assert property (1'b1 |=> timer_output_oe_b == $past({port1_direction[6], port1_direction[5]}))
        else $error("pin enables do not follow direction bits");
    dir_write_a: assert property (bus_wr && bus_addr == ADDR_PORT1_DIR |=> port1_direction == $past(bus_wdata))
        else $error("direction write lost");
    dir_read_a: assert property (bus_addr == ADDR_PORT1_DIR |=> bus_rdata == $past(port1_direction))
        else $error("direction read wrong");
    carrier_pad_a: assert property (bus_addr == ADDR_CARRIER |=> bus_rdata[7:3] == 5'h00)
        else $error("carrier unused bits not zero");
    stop_quiet_a: assert property ((!mode_reg[7] && $stable(mode_reg))[*3] |->
        !match_interrupt[0] && timer_output_pin[0] == mode_reg[1]) else $error("stopped timer not at default");
    idle_gate_a: assert property ((!mode_reg[0] && $stable(mode_reg))[*3] |-> timer_output_pin[0] == mode_reg[1])
        else $error("gated output not at idle level");
    irq_gap_a: assert property (steady && match_interrupt[0] |-> gap_reg == {2'b00, per_reg} + 10'h001)
        else $error("interrupt spacing wrong");
    pin_flip_a: assert property (steady && mode_reg[0] && match_interrupt[0] |->
        ##[0:2] timer_output_pin[0] != $past(timer_output_pin[0])) else $error("output did not invert on match");
endmodule : tmh_timer_ctrl_chk

bind tmh_timer_ctrl tmh_timer_ctrl_chk chk_u (.clk(clk), .rst_b(rst_b), .bus_addr(bus_addr), .bus_wr(bus_wr),
    .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .companion_timer(companion_timer),
    .carrier_transfer(carrier_transfer), .timer_output_pin(timer_output_pin),
    .timer_output_oe_b(timer_output_oe_b), .match_interrupt(match_interrupt), .port1_direction(port1_direction));

// >>> bench/tb_tmh_timer_ctrl.sv
// Purpose: self-checking bench of the dual timer control block
// Assumes: 100 MHz clock, companion output toggles every 4 cycles
// Notes:   table rows measure interrupt spacing per clock code
`timescale 1ns/10ps

module tb_tmh_timer_ctrl;
    import tmh_pkg::*;
    typedef struct { int unit; logic [7:0] mode; int gap; } tmh_row_type;
    logic        clk = 1'b0;
    logic        rst_b = 1'b0;
    logic [15:0] bus_addr = 16'h0000;
    logic        bus_wr = 1'b0;
    logic [7:0]  bus_wdata = 8'h00;
    logic [7:0]  bus_rdata;
    logic        companion_timer = 1'b0;
    logic        carrier_transfer = 1'b0;
    logic [1:0]  timer_output_pin;
    logic [1:0]  timer_output_oe_b;
    logic [1:0]  match_interrupt;
    logic [7:0]  port1_direction;
    logic [2:0]  comp_cnt = 3'h0;
    int          miscompares = 0;
    int          checks_done = 0;
    tmh_row_type rows [8] = '{'{0, 8'h81, 6}, '{0, 8'h91, 12}, '{0, 8'ha1, 24}, '{0, 8'hb1, 384},
        '{0, 8'hc1, 6144}, '{0, 8'hd1, 48}, '{1, 8'h81, 6}, '{1, 8'h91, 24}};

    tmh_timer_ctrl dut_u (.clk(clk), .rst_b(rst_b), .bus_addr(bus_addr), .bus_wr(bus_wr), .bus_wdata(bus_wdata),
        .bus_rdata(bus_rdata), .companion_timer(companion_timer), .carrier_transfer(carrier_transfer),
        .timer_output_pin(timer_output_pin), .timer_output_oe_b(timer_output_oe_b),
        .match_interrupt(match_interrupt), .port1_direction(port1_direction));

    always #5 clk = ~clk;

    always @(posedge clk)
    begin
        comp_cnt <= comp_cnt + 3'h1;
        companion_timer <= comp_cnt[2];
    end

    task automatic tally_and_finish();
        $display("checks %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : tally_and_finish

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            miscompares++;
            $display("unexpected at %0t: value %h want %h", $time, got, exp);
        end
    endtask : chk8

    task automatic chk_n(input int got, input int exp);
        checks_done++;
        if (got != exp)
        begin
            miscompares++;
            $display("unexpected at %0t: count %0d want %0d", $time, got, exp);
        end
    endtask : chk_n

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        bus_addr  <= a;
        bus_wdata <= d;
        bus_wr    <= 1'b1;
        @(posedge clk);
        bus_wr    <= 1'b0;
    endtask : wr

    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        @(posedge clk);
        bus_addr <= a;
        @(posedge clk);
        #1;
        chk8(bus_rdata, e);
    endtask : rd

    task automatic wirq(input int u, output int n);
        n = 0;
        do
        begin
            @(posedge clk);
            #1;
            n++;
        end
        while (match_interrupt[u] !== 1'b1 && n < 20000);
    endtask : wirq

    task automatic xfer();
        @(posedge clk);
        carrier_transfer <= 1'b1;
        repeat (6) @(posedge clk);
        carrier_transfer <= 1'b0;
        repeat (2) @(posedge clk);
    endtask : xfer

    initial
    begin
        repeat (60000) @(posedge clk);
        miscompares++;
        tally_and_finish();
    end

    initial
    begin
        int          n;
        int          u;
        logic        a;
        logic [15:0] ma;
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        #1;
        chk8(port1_direction, RST_PORT1_DIR);
        chk8({6'h00, timer_output_oe_b}, 8'h03);
        rd(ADDR_MODE0, 8'h00);
        rd(ADDR_MODE1, 8'h00);
        rd(ADDR_CARRIER, 8'h00);
        wr(ADDR_PORT1_DIR, 8'h9f);
        rd(ADDR_PORT1_DIR, 8'h9f);
        chk8({6'h00, timer_output_oe_b}, 8'h00);
        rd(16'hff00, 8'h00);
        wr(ADDR_DUTY0, 8'h01);
        foreach (rows[i])
        begin
            u = rows[i].unit;
            ma = u ? ADDR_MODE1 : ADDR_MODE0;
            wr(ma, {1'b0, rows[i].mode[6:0]});
            wr(u ? ADDR_PERIOD1 : ADDR_PERIOD0, 8'h05);
            wr(ma, rows[i].mode);
            wirq(u, n);
            wirq(u, n);
            chk_n(n, rows[i].gap);
            repeat (3) @(posedge clk);
            #1;
            a = timer_output_pin[u];
            wirq(u, n);
            repeat (3) @(posedge clk);
            #1;
            chk8({7'h00, timer_output_pin[u]}, {7'h00, ~a});
            wr(ma, 8'h00);
        end
        wr(ADDR_MODE0, 8'h09);
        wr(ADDR_DUTY0, 8'h02);
        wr(ADDR_MODE0, 8'h89);
        wirq(0, n);
        wirq(0, n);
        chk_n(n, 6);
        repeat (2) @(posedge clk);
        #1;
        chk8({7'h00, timer_output_pin[0]}, 8'h00);
        repeat (3) @(posedge clk);
        #1;
        chk8({7'h00, timer_output_pin[0]}, 8'h01);
        wr(ADDR_MODE0, 8'h09);
        wr(ADDR_MODE0, 8'h03);
        wr(ADDR_MODE0, 8'h83);
        wirq(0, n);
        wr(ADDR_MODE0, 8'h03);
        repeat (3) @(posedge clk);
        #1;
        chk8({6'h00, timer_output_pin[0], match_interrupt[0]}, 8'h02);
        wr(ADDR_MODE0, 8'h02);
        wr(ADDR_MODE0, 8'h82);
        wirq(0, n);
        repeat (3) @(posedge clk);
        #1;
        chk8({7'h00, timer_output_pin[0]}, 8'h01);
        wr(ADDR_CARRIER, 8'hff);
        rd(ADDR_CARRIER, 8'h06);
        xfer();
        rd(ADDR_CARRIER, 8'h07);
        wr(ADDR_CARRIER, 8'h02);
        wr(ADDR_MODE1, 8'h05);
        wr(ADDR_DUTY1, 8'h02);
        wr(ADDR_MODE1, 8'h85);
        repeat (10) @(posedge clk);
        #1;
        chk8({7'h00, timer_output_pin[1]}, 8'h01);
        wr(ADDR_CARRIER, 8'h00);
        xfer();
        rd(ADDR_CARRIER, 8'h00);
        chk8({7'h00, timer_output_pin[1]}, 8'h00);
        @(posedge clk);
        rst_b <= 1'b0;
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        rd(ADDR_MODE1, 8'h00);
        chk8(port1_direction, RST_PORT1_DIR);
        chk8({6'h00, timer_output_oe_b}, 8'h03);
        tally_and_finish();
    end
endmodule : tb_tmh_timer_ctrl
